// >>> core/wgss_pkg.sv
// Purpose: shared constants of the waveform generator source select block
// Assumes: 200 MHz core clock, byte-wide registers on a 32-bit bus
// Notes:   register words are word aligned, data in the low byte
package wgss_pkg;

  // ==========================================================
  // timing
  localparam int CLK_HZ      = 200_000_000;
  localparam int FAST_OSC_HZ = 16_000_000;
  // fast oscillator period rounded down to whole core cycles
  localparam int OSC_DIV_CYC = CLK_HZ / FAST_OSC_HZ;
  localparam int DIV_W       = 4;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CLK_SEL  = 8'h00;
  localparam logic [7:0] OFF_IN_SEL   = 8'h04;
  localparam logic [7:0] OFF_DB_RISE  = 8'h08;
  localparam logic [7:0] OFF_DB_FALL  = 8'h0c;
  localparam logic [7:0] OFF_CTRL0    = 8'h10;
  localparam logic [7:0] OFF_CTRL1    = 8'h14;
  localparam logic [7:0] OFF_SHUT_CTL = 8'h18;
  localparam logic [7:0] OFF_SHUT_SRC = 8'h1c;
  localparam logic [7:0] OFF_STEER    = 8'h20;

  // ==========================================================
  // field positions
  localparam int CS_BIT    = 0;
  localparam int IS_LSB    = 0;
  localparam int IS_W      = 4;
  localparam int DB_W      = 6;
  localparam int EN_BIT    = 7;
  localparam int LD_BIT    = 6;
  localparam int MODE_LSB  = 0;
  localparam int MODE_W    = 3;
  localparam int IN_BIT    = 5;
  localparam int POL_LSB   = 0;
  localparam int SHUT_LSB  = 2;
  localparam int SHUT_W    = 6;
  localparam int SRC_W     = 7;
  localparam int STR_LSB   = 0;
  localparam int OVR_LSB   = 4;
  localparam int NOUT      = 4;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_CLK_SEL = 8'h00;
  localparam logic [7:0] RST_IN_SEL  = 8'h00;
  localparam logic [7:0] RST_OTHER   = 8'h00;

  // ==========================================================
  // encodings
  localparam logic [2:0] MODE_BUFFERED = 3'h1;
  localparam logic [3:0] IS_CLK_PIN = 4'h0;
  localparam logic [3:0] IS_CCP1    = 4'h1;
  localparam logic [3:0] IS_CCP2    = 4'h2;
  localparam logic [3:0] IS_CCP3    = 4'h3;
  localparam logic [3:0] IS_CCP4    = 4'h4;
  localparam logic [3:0] IS_LC1     = 4'h5;
  localparam logic [3:0] IS_LC2     = 4'h6;
  localparam logic [3:0] IS_PWM3    = 4'h9;
  localparam logic [3:0] IS_PWM4    = 4'ha;
  localparam int NSRC = 9;

endpackage

// >>> core/wgss_src_if.sv
// Purpose: carrier between register core and source selector
// Assumes: single clock domain
// Notes:   gen_tick is a one-cycle enable of the generator rate
interface wgss_src_if;
  logic [3:0] isel;
  logic       cs;
  logic       gen_data;
  logic       gen_tick;
  modport sel  (input isel, input cs, output gen_data, output gen_tick);
  modport core (output isel, output cs, input gen_data, input gen_tick);
endinterface

// >>> core/wgss_src_sel.sv
// Purpose: synchronise generator sources, pick one, make the rate tick
// Assumes: sources are asynchronous to clk_i
// Notes:   reserved select codes give a constant low input
module wgss_src_sel
  import wgss_pkg::*;
#(
  parameter int DIV_CYC = OSC_DIV_CYC
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic [NSRC-1:0] src_i,
  wgss_src_if.sel              src
);

  typedef struct packed {
    logic [NSRC-1:0]  sync1;
    logic [NSRC-1:0]  sync2;
    logic [DIV_W-1:0] div;
  } wgss_sel_s;

  wgss_sel_s s;
  wgss_sel_s next_s;

  // ==========================================================
  // source mux
  function automatic logic pick(input logic [3:0] code,
                                input logic [NSRC-1:0] v);
    logic r;
    r = 1'b0;
    case (code)
      IS_CLK_PIN: r = v[0];
      IS_CCP1:    r = v[1];
      IS_CCP2:    r = v[2];
      IS_CCP3:    r = v[3];
      IS_CCP4:    r = v[4];
      IS_LC1:     r = v[5];
      IS_LC2:     r = v[6];
      IS_PWM3:    r = v[7];
      IS_PWM4:    r = v[8];
      default:    r = 1'b0;
    endcase
    return r;
  endfunction

  always_comb begin
    next_s       = s;
    next_s.sync1 = src_i;
    next_s.sync2 = s.sync1;
    if (s.div == DIV_W'(DIV_CYC - 1)) begin
      next_s.div = '0;
    end else begin
      next_s.div = s.div + DIV_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign src.gen_data = pick(src.isel, s.sync2); // R02 R03
  // fast oscillator is an enable pulse, system clock ticks every cycle
  assign src.gen_tick = src.cs ? (s.div == '0) : 1'b1; // R01

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_fast_tick;
    src.cs && src.gen_tick ##1 src.cs;
  endsequence

  a_sys_clk_tick:  assert property (!src.cs |-> src.gen_tick) // R01
    else $error("system clock choice must tick every cycle");
  a_fast_clk_gap:  assert property (s_fast_tick |-> !src.gen_tick) // R01
    else $error("fast oscillator tick repeated on next cycle");
  a_fast_clk_due:  assert property ($rose(src.cs) |-> ##[0:12] src.gen_tick)
    else $error("fast oscillator tick missing");
  a_mux_ccp1:      assert property (src.isel == IS_CCP1 |->
                                    src.gen_data == s.sync2[1]) // R02
    else $error("code 1 must route capture compare output 1");
  a_mux_pwm4:      assert property (src.isel == IS_PWM4 |->
                                    src.gen_data == s.sync2[8]) // R02
    else $error("code a must route pulse width output 4");
  a_reserved_none: assert property ((src.isel == 4'h7 || src.isel == 4'h8 ||
                                     src.isel > IS_PWM4) |->
                                    !src.gen_data) // R03
    else $error("reserved code connected a source");

endmodule

// >>> core/wgss_top.sv
// Purpose: register map, source and clock choice, output steering
// Assumes: classic wishbone master, one request at a time
// Notes:   dead-band counts and shutdown fields are stored only
//
// Notes on behaviour
// R01: clock select 1 picks fast oscillator
// R02: input select codes route listed sources
// R03: reserved input codes connect nothing
// R04: unimplemented bits always read zero
// R05: mode 001 double-buffers steering enables
// R06: steered output carries data with polarity
// R07: unsteered output carries override data bit
// R08: each instance keeps its own settings
//
// Local design decisions: the placing of the registers and register access over Wishbone.
module wgss_top
  import wgss_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        dedicated_clock_pin_input_i,
  input  wire logic        capture_compare_output_1_i,
  input  wire logic        capture_compare_output_2_i,
  input  wire logic        capture_compare_output_3_i,
  input  wire logic        capture_compare_output_4_i,
  input  wire logic        logic_cell_output_1_i,
  input  wire logic        logic_cell_output_2_i,
  input  wire logic        pulse_width_output_3_i,
  input  wire logic        pulse_width_output_4_i,
  output logic             generator_data_o,
  output logic [NOUT-1:0]  waveform_out_o
);

  // ==========================================================
  // state: every instance owns all of it, nothing is shared
  typedef struct packed {
    logic              cs;
    logic [IS_W-1:0]   isel;
    logic [DB_W-1:0]   db_rise;
    logic [DB_W-1:0]   db_fall;
    logic              en;
    logic              ld;
    logic [MODE_W-1:0] mode;
    logic [NOUT-1:0]   pol;
    logic [SHUT_W-1:0] shut_ctl;
    logic [SRC_W-1:0]  shut_src;
    logic [NOUT-1:0]   ovr;
    logic [NOUT-1:0]   str_new;
    logic [NOUT-1:0]   str_act;
    logic              data;
    logic              ack;
    logic [7:0]        rdat;
    logic [NOUT-1:0]   out;
  } wgss_top_s;

  wgss_top_s s; // R08
  wgss_top_s next_s;

  wgss_src_if src ();

  logic req;
  logic wr;
  logic upd;

  // ==========================================================
  // source selector
  wgss_src_sel #(
    .DIV_CYC (OSC_DIV_CYC)
  ) u_src (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .src_i ({pulse_width_output_4_i, pulse_width_output_3_i,
             logic_cell_output_2_i, logic_cell_output_1_i,
             capture_compare_output_4_i, capture_compare_output_3_i,
             capture_compare_output_2_i, capture_compare_output_1_i,
             dedicated_clock_pin_input_i}),
    .src   (src.sel)
  );

  assign src.isel = s.isel; // R02
  assign src.cs   = s.cs; // R01

  // ==========================================================
  // register read decode
  function automatic logic [7:0] rd_reg(input logic [7:0] a,
                                        input wgss_top_s v);
    logic [7:0] r;
    r = 8'h00;
    if (a == OFF_CLK_SEL) begin
      r[CS_BIT] = v.cs;
    end else if (a == OFF_IN_SEL) begin
      r[IS_LSB +: IS_W] = v.isel;
    end else if (a == OFF_DB_RISE) begin
      r[DB_W-1:0] = v.db_rise;
    end else if (a == OFF_DB_FALL) begin
      r[DB_W-1:0] = v.db_fall;
    end else if (a == OFF_CTRL0) begin
      r[EN_BIT]              = v.en;
      r[LD_BIT]              = v.ld;
      r[MODE_LSB +: MODE_W]  = v.mode;
    end else if (a == OFF_CTRL1) begin
      r[IN_BIT]              = v.data;
      r[POL_LSB +: NOUT]     = v.pol;
    end else if (a == OFF_SHUT_CTL) begin
      r[SHUT_LSB +: SHUT_W]  = v.shut_ctl;
    end else if (a == OFF_SHUT_SRC) begin
      r[SRC_W-1:0]           = v.shut_src;
    end else if (a == OFF_STEER) begin
      r[OVR_LSB +: NOUT]     = v.ovr;
      r[STR_LSB +: NOUT]     = v.str_new;
    end
    return r; // R04
  endfunction

  // ==========================================================
  // next state
  assign req = wb_cyc_i && wb_stb_i;
  // a write lands on the edge where ack is seen high
  assign wr  = req && s.ack && wb_we_i && wb_sel_i[0];
  // buffered update point: rising edge of the sampled input
  assign upd = src.gen_tick && s.en && src.gen_data && !s.data;

  always_comb begin
    next_s     = s;
    next_s.ack = req && !s.ack;
    if (req && !s.ack) begin
      next_s.rdat = rd_reg(wb_adr_i, s);
    end
    if (wr) begin
      if (wb_adr_i == OFF_CLK_SEL) begin
        next_s.cs = wb_dat_i[CS_BIT];
      end else if (wb_adr_i == OFF_IN_SEL) begin
        next_s.isel = wb_dat_i[IS_LSB +: IS_W];
      end else if (wb_adr_i == OFF_DB_RISE) begin
        next_s.db_rise = wb_dat_i[DB_W-1:0];
      end else if (wb_adr_i == OFF_DB_FALL) begin
        next_s.db_fall = wb_dat_i[DB_W-1:0];
      end else if (wb_adr_i == OFF_CTRL0) begin
        next_s.en   = wb_dat_i[EN_BIT];
        next_s.ld   = wb_dat_i[LD_BIT];
        next_s.mode = wb_dat_i[MODE_LSB +: MODE_W];
      end else if (wb_adr_i == OFF_CTRL1) begin
        next_s.pol = wb_dat_i[POL_LSB +: NOUT];
      end else if (wb_adr_i == OFF_SHUT_CTL) begin
        next_s.shut_ctl = wb_dat_i[SHUT_LSB +: SHUT_W];
      end else if (wb_adr_i == OFF_SHUT_SRC) begin
        next_s.shut_src = wb_dat_i[SRC_W-1:0];
      end else if (wb_adr_i == OFF_STEER) begin
        next_s.ovr     = wb_dat_i[OVR_LSB +: NOUT];
        next_s.str_new = wb_dat_i[STR_LSB +: NOUT];
      end
    end
    // generator input sampled at the chosen rate, low when disabled
    if (src.gen_tick) begin
      next_s.data = s.en && src.gen_data; // R01
    end
    // buffered mode holds new enables until the update point
    if (s.mode != MODE_BUFFERED || upd) begin
      next_s.str_act = s.str_new; // R05
    end
    for (int i = 0; i < NOUT; i++) begin
      if (s.str_act[i]) begin
        next_s.out[i] = s.data ^ s.pol[i]; // R06
      end else begin
        next_s.out[i] = s.ovr[i]; // R07
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s         <= '0;
      s.cs      <= RST_CLK_SEL[CS_BIT];
      s.isel    <= RST_IN_SEL[IS_LSB +: IS_W];
      s.str_new <= RST_OTHER[STR_LSB +: NOUT];
    end else begin
      s <= next_s;
    end
  end

  assign wb_ack_o         = s.ack;
  assign wb_dat_o         = {24'h000000, s.rdat};
  assign generator_data_o = s.data;
  assign waveform_out_o   = s.out;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_new_req;
    req && !s.ack;
  endsequence

  sequence s_held_buffered;
    s.mode == MODE_BUFFERED && !upd;
  endsequence

  a_ack_follows:   assert property (s_new_req |=> wb_ack_o)
    else $error("ack not given one cycle after request");
  a_ack_single:    assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held for more than one cycle");
  a_clk_sel_zero:  assert property (wb_ack_o && !wb_we_i &&
                                    $past(wb_adr_i) == OFF_CLK_SEL |->
                                    wb_dat_o[31:1] == '0) // R04
    else $error("clock select upper bits not zero");
  a_in_sel_zero:   assert property (wb_ack_o && !wb_we_i &&
                                    $past(wb_adr_i) == OFF_IN_SEL |->
                                    wb_dat_o[31:4] == '0) // R04
    else $error("input select upper bits not zero");
  a_buf_hold:      assert property (s_held_buffered |=>
                                    $stable(s.str_act)) // R05
    else $error("buffered steering changed off the update point");
  a_unbuf_follow:  assert property (s.mode != MODE_BUFFERED |=>
                                    s.str_act == $past(s.str_new)) // R05
    else $error("unbuffered steering did not follow the register");
  a_steer_data:    assert property (s.str_act[0] |=>
                                    waveform_out_o[0] ==
                                    ($past(s.data) ^ $past(s.pol[0]))) // R06
    else $error("steered output lost data or polarity");
  a_steer_ovr:     assert property (!s.str_act[1] |=>
                                    waveform_out_o[1] ==
                                    $past(s.ovr[1])) // R07
    else $error("unsteered output ignored override bit");
  a_cs_write:      assert property (wr && wb_adr_i == OFF_CLK_SEL |=>
                                    src.cs == $past(wb_dat_i[0])) // R01
    else $error("clock select write not taken");
  a_own_settings:  assert property (!wr |=> $stable(s.isel)
                                    && $stable(s.cs)) // R08
    else $error("settings changed without a write");

  // ==========================================================
  // unimplemented bits of the remaining registers
  a_high_lanes:    assert property (wb_ack_o |-> wb_dat_o[31:8] == '0) // R04
    else $error("read data above the low byte not zero");
  a_dbr_zero:      assert property (wb_ack_o && !wb_we_i &&
                                    $past(wb_adr_i) == OFF_DB_RISE |->
                                    wb_dat_o[7:DB_W] == '0) // R04
    else $error("rising dead-band upper bits not zero");
  a_dbf_zero:      assert property (wb_ack_o && !wb_we_i &&
                                    $past(wb_adr_i) == OFF_DB_FALL |->
                                    wb_dat_o[7:DB_W] == '0) // R04
    else $error("falling dead-band upper bits not zero");
  a_ctrl0_zero:    assert property (wb_ack_o && !wb_we_i &&
                                    $past(wb_adr_i) == OFF_CTRL0 |->
                                    wb_dat_o[LD_BIT-1:MODE_W] == '0) // R04
    else $error("control zero gap bits not zero");
  a_ctrl1_zero:    assert property (wb_ack_o && !wb_we_i &&
                                    $past(wb_adr_i) == OFF_CTRL1 |->
                                    wb_dat_o[7:IN_BIT+1] == '0 &&
                                    wb_dat_o[IN_BIT-1:NOUT] == '0) // R04
    else $error("control one gap bits not zero");
  a_shut_ctl_zero: assert property (wb_ack_o && !wb_we_i &&
                                    $past(wb_adr_i) == OFF_SHUT_CTL |->
                                    wb_dat_o[SHUT_LSB-1:0] == '0) // R04
    else $error("shutdown control low bits not zero");
  a_shut_src_zero: assert property (wb_ack_o && !wb_we_i &&
                                    $past(wb_adr_i) == OFF_SHUT_SRC |->
                                    wb_dat_o[7:SRC_W] == '0) // R04
    else $error("shutdown source top bit not zero");

  // ==========================================================
  // generator data path
  // data is only sampled on a tick, so the data checks wait for one
  sequence s_reserved_tick;
    (s.isel == 4'h7 || s.isel == 4'h8 || s.isel > IS_PWM4) && src.gen_tick;
  endsequence

  sequence s_update_point;
    s.mode == MODE_BUFFERED && upd;
  endsequence

  a_sys_follow:    assert property (!s.cs && s.en |=>
                                    generator_data_o ==
                                    $past(src.gen_data)) // R01
    else $error("system clock choice did not sample every cycle");
  a_off_low:       assert property (!s.en && src.gen_tick |=>
                                    !generator_data_o)
    else $error("disabled generator data not low");
  a_reserved_low:  assert property (s_reserved_tick |=>
                                    !generator_data_o) // R03
    else $error("reserved code gave generator data");
  a_buf_apply:     assert property (s_update_point |=>
                                    s.str_act == $past(s.str_new)) // R05
    else $error("buffered steering not applied at update point");
  a_sel_masked:    assert property (req && s.ack && wb_we_i &&
                                    !wb_sel_i[0] |=> $stable(s.cs))
    else $error("write with lane 0 disabled changed clock select");
  a_ack_idle:      assert property (!req |=> !wb_ack_o)
    else $error("ack given without a request");

  // ==========================================================
  // every output, not only the first two
  for (genvar g = 0; g < NOUT; g++) begin : g_steer_chk
    a_out_data: assert property (s.str_act[g] |=>
                                 waveform_out_o[g] ==
                                 ($past(s.data) ^ $past(s.pol[g]))) // R06
      else $error("steered output lost data or polarity");
    a_out_ovr:  assert property (!s.str_act[g] |=>
                                 waveform_out_o[g] == $past(s.ovr[g])) // R07
      else $error("unsteered output ignored override bit");
  end

endmodule

// >>> test/wgss_src_model.sv
// Purpose: far-side peripheral outputs feeding the generator sources
// Assumes: peripheral levels move only just after a clock edge
// Notes:   bit order pin, capture 1-4, logic cell 1-2, pulse width 3-4
module wgss_src_model (
  input  wire logic       clk_i,
  input  wire logic [8:0] lvl_i,
  output logic      [8:0] src_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================
  // outputs
  // registered so the levels never change on the sampling edge itself
  always_ff @(posedge clk_i) begin
    src_o <= lvl_i;
  end
endmodule

// >>> test/testbench.sv
// Purpose: register, routing, steering and clock choice checks
// Assumes: single request at a time, ack one cycle after the request
// Notes:   second instance sits idle on the bus to show separate state
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc   = 1'b0;
  logic        we    = 1'b0;
  logic [7:0]  adr   = 8'h00;
  logic [3:0]  sel   = 4'h0;
  logic [31:0] wdat  = 32'h0;
  logic [31:0] rdat;
  logic        ack;
  logic [8:0]  lvl   = 9'h000;
  logic [8:0]  src;
  logic        gd;
  logic        gd_b;
  logic [3:0]  wf;
  logic [3:0]  wf_b;
  int          n_mismatch = 0;
  int          checked    = 0;
  int          n;
  int          mx;
  int          idx;

  always #2.5 clk_i = ~clk_i;

  // ==========================================================
  // design and far side
  wgss_src_model wgss_src_model_inst (.clk_i(clk_i), .lvl_i(lvl),
                                      .src_o(src));

  wgss_top wgss_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .dedicated_clock_pin_input_i(src[0]),
    .capture_compare_output_1_i(src[1]), .capture_compare_output_2_i(src[2]),
    .capture_compare_output_3_i(src[3]), .capture_compare_output_4_i(src[4]),
    .logic_cell_output_1_i(src[5]), .logic_cell_output_2_i(src[6]),
    .pulse_width_output_3_i(src[7]), .pulse_width_output_4_i(src[8]),
    .generator_data_o(gd), .waveform_out_o(wf));

  // never selected: its settings must stay at reset whatever the other does
  wgss_top wgss_top_inst_b (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(1'b0),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(), .wb_ack_o(),
    .dedicated_clock_pin_input_i(src[0]),
    .capture_compare_output_1_i(src[1]), .capture_compare_output_2_i(src[2]),
    .capture_compare_output_3_i(src[3]), .capture_compare_output_4_i(src[4]),
    .logic_cell_output_1_i(src[5]), .logic_cell_output_2_i(src[6]),
    .pulse_width_output_3_i(src[7]), .pulse_width_output_4_i(src[8]),
    .generator_data_o(gd_b), .waveform_out_o(wf_b));

  // ==========================================================
  // helpers
  task automatic stop_test;
    $display("compares %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask

  // classic cycle: data taken at the edge where ack is seen high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s,
                     output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= s;
    // ack and read data are seen as they stood at the edge itself
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    if (ack !== 1'b1) begin
      n_mismatch++;
      stop_test();
    end
    q = rdat;
    cyc <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, a, {24'h0, d}, 4'hf, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'h0, q);
    chk(q, e);
  endtask

  // cycles from the request edge until generator data shows v
  task automatic wait_gd(input logic v, output int c);
    c = 0;
    do begin
      @(posedge clk_i);
      #1;
      c++;
    end while (gd !== v && c < 40);
    if (gd !== v) begin
      n_mismatch++;
      stop_test();
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    logic [31:0] q;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    wr(8'h00, 8'hff);
    rd(8'h00, 32'h1);
    wr(8'h04, 8'hff);
    rd(8'h04, 32'hf);
    bus(1'b1, 8'h00, 32'h0, 4'h0, q);
    rd(8'h00, 32'h1);
    rd(8'h24, 32'h0);
    // unimplemented bits of the other registers
    wr(8'h08, 8'hff);
    rd(8'h08, 32'h3f);
    wr(8'h0c, 8'hff);
    rd(8'h0c, 32'h3f);
    wr(8'h18, 8'hff);
    rd(8'h18, 32'hfc);
    wr(8'h1c, 8'hff);
    rd(8'h1c, 32'h7f);
    wr(8'h10, 8'hff);
    rd(8'h10, 32'hc7);
    wr(8'h10, 8'h00);
    wr(8'h14, 8'hff);
    rd(8'h14, 32'h0f);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h00);
    // buffered steering: enables wait for the rising data edge
    wr(8'h14, 8'h0f);
    wr(8'h10, 8'h81);
    wr(8'h20, 8'h0f);
    repeat (8) @(posedge clk_i);
    #1 chk(wf, 4'h0);
    rd(8'h20, 32'hf);
    lvl <= 9'h001;
    wait_gd(1'b1, n);
    rd(8'h14, 32'h2f);
    lvl <= 9'h000;
    wait_gd(1'b0, n);
    @(posedge clk_i);
    #1 chk(wf, 4'hf);
    wr(8'h10, 8'h80);
    wr(8'h20, 8'ha0);
    repeat (3) @(posedge clk_i);
    #1 chk(wf, 4'ha);
    wr(8'h14, 8'h00);
    wr(8'h20, 8'h0f);
    // every select code, reserved ones with all sources high
    for (int c = 0; c < 16; c++) begin
      wr(8'h04, c[7:0]);
      idx = (c < 7) ? c : (c == 9) ? 7 : (c == 10) ? 8 : 9;
      if (idx < 9) begin
        lvl <= 9'h001 << idx;
        wait_gd(1'b1, n);
        chk(n, 4);
        @(posedge clk_i);
        #1 chk(wf, 4'hf);
      end else begin
        lvl <= 9'h1ff;
        repeat (8) @(posedge clk_i);
        #1 chk(gd, 1'b0);
      end
      lvl <= 9'h000;
      repeat (6) @(posedge clk_i);
    end
    // fast oscillator: data moves only on its ticks
    wr(8'h04, 8'h01);
    wr(8'h00, 8'h01);
    mx = 0;
    for (int i = 0; i < 6; i++) begin
      lvl <= 9'h002;
      wait_gd(1'b1, n);
      chk(n <= 15, 1'b1);
      mx = (n > mx) ? n : mx;
      lvl <= 9'h000;
      wait_gd(1'b0, n);
      repeat (i + 1) @(posedge clk_i);
    end
    chk(mx > 4, 1'b1);
    chk(wf_b, 4'h0);
    chk(gd_b, 1'b0);
    stop_test();
  end
endmodule
